// file: hw/npc_pkg.sv
// Package with constants and types for the nap mode power controller
package npc_pkg;

  // Vector offset of the system management exception
  localparam logic [19:0] NPC_MGMT_VECTOR  = 20'h0_1400;
  // Value of the power-save bit after reset
  localparam logic        NPC_PSAVE_RESET  = 1'b0;
  // Cycles the clock gate settles before the indicator rises
  localparam int          NPC_GATE_SETTLE  = 2;
  localparam logic [3:0]  NPC_SETTLE_CYC   = 4'(NPC_GATE_SETTLE);

  typedef enum logic [2:0] {
    NPC_RUN,
    NPC_DRAIN,
    NPC_GATE,
    NPC_NAP,
    NPC_SNOOP
  } npc_state_type;

endpackage : npc_pkg

// file: hw/npc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module npc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;

endmodule : npc_sync

// file: hw/npc_nap_ctrl.sv
// Nap mode power controller: drain, clock gate, indicator, wake
// Notes on behaviour
// [R01] Setting the power-save bit starts entry into nap.
// [R02] With the bit set, dispatch stops until bus work has drained.
// [R03] After draining, gate clocks, then raise the nap indicator.
// [R04] In nap only decrementer, time base and interrupt logic keep clocks.
// [R05] No snooping in nap unless system logic asserts wake-for-snoop.
// [R06] Wake-for-snoop asserted drops the nap indicator.
// [R07] An asynchronous exception ends nap, restarts clocks, clears the bit.
// [R08] Management interrupt with external enable set raises its exception.
// [R09] Wake-for-snoop released with snoop done raises the indicator again.
`timescale 1ns/1ns
module npc_nap_ctrl
  import npc_pkg::*;
#(
  parameter int N_ASYNC = 4
) (
  input  wire logic               I_REF_CLK,
  input  wire logic               I_RSTN,
  input  wire logic               I_PSAVE_SET,
  input  wire logic               I_PSAVE_CLR,
  input  wire logic               I_EXT_INT_EN,
  input  wire logic               I_BUS_BUSY,
  input  wire logic               I_CORE_BUSY,
  input  wire logic               I_SNOOP_BUSY,
  input  wire logic               I_SNOOP_WAKE,
  input  wire logic               I_SYS_MGMT_INT_N,
  input  wire logic [N_ASYNC-1:0] I_ASYNC_EXC,
  output logic                    O_POWER_SAVE,
  output logic                    O_DISPATCH_STALL,
  output logic                    O_CORE_CLK_EN,
  output logic                    O_TIMER_CLK_EN,
  output logic                    O_SNOOP_EN,
  output logic                    O_NAP_IND,
  output logic                    O_MGMT_EXC,
  output logic                    O_WAKE
);

  npc_state_type state;
  npc_state_type next_state;
  logic          psave;
  logic          next_psave;
  logic [3:0]    settle;
  logic [3:0]    next_settle;
  logic          dispatch_stall;
  logic          next_dispatch_stall;
  logic          core_clk_en;
  logic          next_core_clk_en;
  logic          snoop_en;
  logic          next_snoop_en;
  logic          nap_ind;
  logic          next_nap_ind;
  logic          mgmt_exc;
  logic          next_mgmt_exc;
  logic          timer_clk_en;
  logic          next_timer_clk_en;
  logic          wake;
  logic          next_wake;

  logic                      snoop_wake_s;
  logic                      mgmt_req_s;
  logic [N_ASYNC-1:0]        async_s;
  logic                      async_exc;

  // Snoop-wake, management and exception pins pass two flip-flops; every stage resets to the idle level
  npc_sync #(
    .WIDTH (1)
  ) u_sync_snoop (
    .i_clk   (I_REF_CLK),
    .i_rstn  (I_RSTN),
    .i_async (I_SNOOP_WAKE),
    .o_sync  (snoop_wake_s)
  );

  // Inverted first, so a cleared stage after reset means no request
  npc_sync #(
    .WIDTH (1)
  ) u_sync_mgmt (
    .i_clk   (I_REF_CLK),
    .i_rstn  (I_RSTN),
    .i_async (!I_SYS_MGMT_INT_N),
    .o_sync  (mgmt_req_s)
  );

  npc_sync #(
    .WIDTH (N_ASYNC)
  ) u_sync_exc (
    .i_clk   (I_REF_CLK),
    .i_rstn  (I_RSTN),
    .i_async (I_ASYNC_EXC),
    .o_sync  (async_s)
  );

  // States in which the core clock is gated
  function automatic logic in_nap_phase(input npc_state_type s);
    return (s == NPC_GATE) || (s == NPC_NAP) || (s == NPC_SNOOP);
  endfunction : in_nap_phase

  // True once no unit holds work in flight
  function automatic logic all_drained(input logic bus, input logic core,
                                       input logic snoop);
    return !bus && !core && !snoop;
  endfunction : all_drained

  always_comb begin
    // Management interrupt counts only with external enable set
    next_mgmt_exc = mgmt_req_s && I_EXT_INT_EN;  // [R08]
    async_exc     = (|async_s) || next_mgmt_exc;
  end

  always_comb begin
    next_state          = state;
    next_psave          = psave;
    next_timer_clk_en   = 1'b1;  // [R04]
    next_settle         = settle;
    next_dispatch_stall = dispatch_stall;
    next_core_clk_en    = core_clk_en;
    next_snoop_en       = snoop_en;
    next_nap_ind        = nap_ind;
    next_wake           = 1'b0;
    if (I_PSAVE_SET) begin
      next_psave = 1'b1;  // [R01]
    end else if (I_PSAVE_CLR) begin
      next_psave = 1'b0;
    end
    case (state)
      NPC_RUN: begin
        next_core_clk_en = 1'b1;
        next_snoop_en    = 1'b1;
        next_nap_ind     = 1'b0;
        if (psave) begin
          next_state          = NPC_DRAIN;  // [R01]
          next_dispatch_stall = 1'b1;       // [R02]
        end else begin
          next_dispatch_stall = 1'b0;
        end
      end
      NPC_DRAIN: begin
        if (!psave) begin
          next_state          = NPC_RUN;
          next_dispatch_stall = 1'b0;
        end else if (all_drained(I_BUS_BUSY, I_CORE_BUSY, I_SNOOP_BUSY)) begin
          next_state       = NPC_GATE;  // [R02]
          next_core_clk_en = 1'b0;      // [R03]
          next_snoop_en    = 1'b0;      // [R05]
          next_settle      = NPC_SETTLE_CYC;
        end
      end
      NPC_GATE: begin
        if (settle > 4'h1) begin
          next_settle = settle - 4'h1;
        end else begin
          next_state   = NPC_NAP;
          next_nap_ind = 1'b1;  // [R03]
        end
      end
      NPC_NAP: begin
        if (snoop_wake_s) begin
          next_state    = NPC_SNOOP;
          next_nap_ind  = 1'b0;  // [R06]
          next_snoop_en = 1'b1;  // [R05]
        end
      end
      NPC_SNOOP: begin
        if (!snoop_wake_s && !I_SNOOP_BUSY) begin
          next_state    = NPC_NAP;
          next_nap_ind  = 1'b1;  // [R09]
          next_snoop_en = 1'b0;
        end
      end
      default: begin
        next_state = NPC_RUN;
      end
    endcase
    // Wake leaves any nap phase; it overrides a same-cycle set
    if (async_exc && in_nap_phase(state)) begin
      next_state          = NPC_RUN;  // [R07]
      next_psave          = 1'b0;     // [R07]
      next_core_clk_en    = 1'b1;     // [R07]
      next_snoop_en       = 1'b1;
      next_nap_ind        = 1'b0;
      next_dispatch_stall = 1'b0;
      next_wake           = 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state          <= NPC_RUN;
      psave          <= NPC_PSAVE_RESET;
      settle         <= '0;
      dispatch_stall <= 1'b0;
      core_clk_en    <= 1'b1;
      snoop_en       <= 1'b1;
      nap_ind        <= 1'b0;
      mgmt_exc       <= 1'b0;
      timer_clk_en   <= 1'b1;
      wake           <= 1'b0;
    end else begin
      state          <= next_state;
      psave          <= next_psave;
      settle         <= next_settle;
      dispatch_stall <= next_dispatch_stall;
      core_clk_en    <= next_core_clk_en;
      snoop_en       <= next_snoop_en;
      nap_ind        <= next_nap_ind;
      mgmt_exc       <= next_mgmt_exc;
      timer_clk_en   <= next_timer_clk_en;
      wake           <= next_wake;
    end
  end

  assign O_POWER_SAVE     = psave;
  assign O_DISPATCH_STALL = dispatch_stall;
  assign O_CORE_CLK_EN    = core_clk_en;
  // Timers and interrupt logic never lose their clock
  assign O_TIMER_CLK_EN   = timer_clk_en;  // [R04]
  assign O_SNOOP_EN       = snoop_en;
  assign O_NAP_IND        = nap_ind;
  assign O_MGMT_EXC       = mgmt_exc;
  assign O_WAKE           = wake;

endmodule : npc_nap_ctrl

// file: bench/npc_bus_model.sv
// Bus controller model holding bus activity for a set count
`timescale 1ns/1ns
module npc_bus_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_len,
  output logic            o_busy
);
  logic [3:0] cnt = 4'h0;
  always @(posedge i_clk) begin
    if (i_len != 4'h0) cnt <= i_len;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign o_busy = (cnt != 4'h0);
endmodule : npc_bus_model

// file: bench/npc_nap_ctrl_asserts.sv
// Port timing checker of the nap controller
`timescale 1ns/1ns
module npc_nap_ctrl_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSAVE_SET,
  input wire logic I_BUS_BUSY,
  input wire logic I_SNOOP_WAKE,
  input wire logic O_POWER_SAVE,
  input wire logic O_DISPATCH_STALL,
  input wire logic O_CORE_CLK_EN,
  input wire logic O_TIMER_CLK_EN,
  input wire logic O_SNOOP_EN,
  input wire logic O_NAP_IND,
  input wire logic O_WAKE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  psave_set_a: assert property (I_PSAVE_SET && O_CORE_CLK_EN |=> O_POWER_SAVE)
    else $error("power bit not set");
  stall_a: assert property ($rose(O_POWER_SAVE) |=> O_DISPATCH_STALL)
    else $error("no stall");
  drain_a: assert property (O_CORE_CLK_EN && I_BUS_BUSY |=> O_CORE_CLK_EN)
    else $error("gated while busy");
  gate_ind_a: assert property ($fell(O_CORE_CLK_EN) |=> !O_NAP_IND ##1 O_NAP_IND)
    else $error("indicator timing");
  timer_on_a: assert property (O_TIMER_CLK_EN)
    else $error("timer clock off");
  no_snoop_a: assert property (O_NAP_IND |-> !O_SNOOP_EN)
    else $error("snoop in nap");
  snoop_drop_a: assert property (O_NAP_IND && I_SNOOP_WAKE |-> ##[1:4] !O_NAP_IND)
    else $error("indicator kept");
  wake_state_a: assert property (O_WAKE |-> !O_POWER_SAVE && O_CORE_CLK_EN)
    else $error("bad wake state");
  cover property (O_WAKE);
  cover property ($rose(O_NAP_IND));
  cover property (O_NAP_IND && I_SNOOP_WAKE);
endmodule : npc_nap_ctrl_asserts
bind npc_nap_ctrl npc_nap_ctrl_asserts chk (.*);

// file: bench/npc_nap_ctrl_tb.sv
// Testbench of the nap controller
`timescale 1ns/1ns
module npc_nap_ctrl_tb;
  logic       I_REF_CLK = 1'h0, I_RSTN = 1'h0, I_PSAVE_SET = 1'h0;
  logic       I_PSAVE_CLR = 1'h0, I_EXT_INT_EN = 1'h0, I_CORE_BUSY = 1'h0;
  logic       I_SNOOP_BUSY = 1'h0, I_SNOOP_WAKE = 1'h0;
  logic       I_SYS_MGMT_INT_N = 1'h1, I_BUS_BUSY, O_POWER_SAVE, O_WAKE;
  logic       O_DISPATCH_STALL, O_CORE_CLK_EN, O_TIMER_CLK_EN, O_SNOOP_EN;
  logic       O_NAP_IND, O_MGMT_EXC;
  logic [3:0] I_ASYNC_EXC = 4'h0, len = 4'h0;
  int         err_total = 0, samples_checked = 0;
  always #5 I_REF_CLK = ~I_REF_CLK;
  npc_nap_ctrl uut (.*);
  npc_bus_model bus (.i_clk(I_REF_CLK), .i_len(len), .o_busy(I_BUS_BUSY));
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge I_REF_CLK);
    #1;
  endtask : cyc
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %0t mismatch", $time);
      err_total++;
      stop_test();
    end
  endtask : chk
  task automatic t_nap(input logic [3:0] n);
    @(posedge I_REF_CLK) I_PSAVE_SET <= 1'h1;
    @(posedge I_REF_CLK) I_PSAVE_SET <= 1'h0;
    len <= n;
    #1;
    chk(O_POWER_SAVE, 1'h1);
    cyc(1);
    len <= 4'h0;
    chk(O_DISPATCH_STALL, 1'h1);
    cyc(n);
    chk(O_CORE_CLK_EN, 1'h1);
    cyc(1);
    chk(O_CORE_CLK_EN, 1'h0);
    for (int k = 0; k < 20 && O_NAP_IND !== 1'h1; k++) cyc(1);
    chk(O_NAP_IND, 1'h1);
    chk(O_CORE_CLK_EN, 1'h0);
    chk(O_SNOOP_EN, 1'h0);
    chk(O_TIMER_CLK_EN, 1'h1);
  endtask : t_nap
  task automatic t_snoop();
    @(posedge I_REF_CLK) I_SNOOP_WAKE <= 1'h1;
    I_SNOOP_BUSY <= 1'h1;
    cyc(4);
    chk(O_NAP_IND, 1'h0);
    chk(O_SNOOP_EN, 1'h1);
    @(posedge I_REF_CLK) I_SNOOP_WAKE <= 1'h0;
    cyc(6);
    chk(O_NAP_IND, 1'h0);
    @(posedge I_REF_CLK) I_SNOOP_BUSY <= 1'h0;
    for (int k = 0; k < 20 && O_NAP_IND !== 1'h1; k++) cyc(1);
    chk(O_NAP_IND, 1'h1);
  endtask : t_snoop
  task automatic t_wake(input int i);
    @(posedge I_REF_CLK) I_ASYNC_EXC[i] <= 1'h1;
    for (int k = 0; k < 20 && O_WAKE !== 1'h1; k++) cyc(1);
    chk(O_WAKE, 1'h1);
    chk(O_POWER_SAVE, 1'h0);
    chk(O_CORE_CLK_EN, 1'h1);
    @(posedge I_REF_CLK) I_ASYNC_EXC[i] <= 1'h0;
  endtask : t_wake
  task automatic t_mgmt();
    @(posedge I_REF_CLK) I_SYS_MGMT_INT_N <= 1'h0;
    cyc(8);
    chk(O_MGMT_EXC, 1'h0);
    @(posedge I_REF_CLK) I_EXT_INT_EN <= 1'h1;
    cyc(4);
    chk(O_MGMT_EXC, 1'h1);
  endtask : t_mgmt
  initial begin
    cyc(16);
    @(posedge I_REF_CLK) I_RSTN <= 1'h1;
    #1;
    chk(O_NAP_IND, 1'h0);
    for (int i = 0; i < 4; i++) begin
      t_nap(4'(i + 2));
      if (i == 0) t_snoop();
      t_wake(i);
    end
    t_mgmt();
    stop_test();
  end
endmodule : npc_nap_ctrl_tb
